// ==== hw/xrsn_edge.sv ====
// xrsn_edge: left and right edge selects driving the two shift pins
// assumes: purely combinational; pins are active low outside, high inside
`timescale 1ns/1ps
`include "xrsn_map.svh"
module xrsn_edge (
  input xrsn_pkg::xrsn_ctrl_t i_ctrl,
  input wire logic [`XRSN_WIDTH-1:0] i_ext_reg,
  input wire logic [`XRSN_WIDTH-1:0] i_alu,
  output xrsn_pkg::xrsn_pin_t o_left,
  output xrsn_pkg::xrsn_pin_t o_right
);
  import xrsn_pkg::*;
  logic left_val;
  logic right_val;
  ////////////////////////////////////////////////////////////////////////////
  // ext_left_edge_select
  always_comb begin
    left_val = i_ext_reg[`XRSN_B3];
    if (i_ctrl.pos == XRSN_POS_MOST) begin
      left_val = (i_ctrl.op == XRSN_OP_LCIR) ? i_alu[`XRSN_B3] : `XRSN_EDGE_HIGH;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ext_right_edge_select
  always_comb begin
    right_val = i_ext_reg[`XRSN_B0];
    if (i_ctrl.pos == XRSN_POS_LEAST) begin
      right_val = i_alu[`XRSN_B0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin drive: enables follow the operation only, not the position
  // op and position select
  assign o_left.oe = xrsn_is_left(i_ctrl.op);
  assign o_right.oe = xrsn_is_right(i_ctrl.op);
  assign o_left.out_n = o_left.oe ? ~left_val : `XRSN_PIN_IDLE;
  assign o_right.out_n = o_right.oe ? ~right_val : `XRSN_PIN_IDLE;
endmodule : xrsn_edge

// ==== hw/xrsn_top.sv ====
// xrsn_top: extended working register, its input select, edge selects and working register
// assumes: op, position and data are synchronous to i_ref_clk; neighbours are identical slices
//
// Summary of operation
// - The left shift pin receives right-shift data into bit 3 or bit 2 and sends left-shift data out.
// - The right shift pin feeds bit 0 on left shifts and sends right-shift data to the neighbour.
// - Both shift pins are active low outside and active high inside, inverted both ways.
// - Loading from the data-out bus copies its four bits unshifted in every slice position.
// - Left shifts load bit 0 from the right pin and bits 1..3 from bits 0..2.
// - Right shifts load bits 0..2 from bits 1..3 and bit 3 from the left pin, except a double-signed arithmetic shift in the top slice.
// - A double-signed arithmetic right shift in the top slice keeps bit 3 and loads bit 2 from the left pin.
// - Below the top slice, left operations drive the left pin from register bit 3.
// - In the top slice, left shifts drive the left pin high and left circulate drives ALU bit 3.
// - Above the bottom slice, right operations drive the right pin from register bit 0.
// - In the bottom slice, right operations drive the right pin from ALU bit 0.
// - Edge selects depend only on the operation and the slice position.
// - The working register takes data-in or the data-out bus as selected.
// - The top slice shows input-select bit 3 on the msb output, the bottom slice bit 0 on the lsb output.
`timescale 1ns/1ps
`include "xrsn_map.svh"
module xrsn_top #(
  parameter int WIDTH = `XRSN_WIDTH
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input xrsn_pkg::xrsn_ctrl_t i_ctrl,
  input xrsn_pkg::xrsn_wr_src_t i_wr_src,
  input wire logic [WIDTH-1:0] i_data_in,
  input wire logic [WIDTH-1:0] i_data_out_bus_bits,
  input wire logic [WIDTH-1:0] i_alu,
  input wire logic i_ext_left_shift_port_n,
  output logic o_ext_left_shift_port_n,
  output logic o_ext_left_shift_port_oe,
  input wire logic i_ext_right_shift_port_n,
  output logic o_ext_right_shift_port_n,
  output logic o_ext_right_shift_port_oe,
  output logic [WIDTH-1:0] o_extended_working_register,
  output logic [WIDTH-1:0] o_work_reg,
  output logic o_ext_msb,
  output logic o_ext_lsb
);
  import xrsn_pkg::*;

  logic [WIDTH-1:0] extended_working_register;
  logic [WIDTH-1:0] work_reg;
  logic [WIDTH-1:0] next_extended_working_register;
  logic [WIDTH-1:0] next_work_reg;
  logic left_in;
  logic right_in;
  logic is_top;
  xrsn_pin_t left_pin;
  xrsn_pin_t right_pin;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs, made active high inside
  // invert from the pin
  assign left_in = ~i_ext_left_shift_port_n;
  assign right_in = ~i_ext_right_shift_port_n;
  assign is_top = (i_ctrl.pos == XRSN_POS_MOST);

  ////////////////////////////////////////////////////////////////////////////
  // ext_reg_input_select
  always_comb begin
    next_extended_working_register = extended_working_register;
    case (i_ctrl.op)
      XRSN_OP_LOAD_BUS: begin
        next_extended_working_register = i_data_out_bus_bits;
      end
      XRSN_OP_LSA_SS, XRSN_OP_LSA_DS, XRSN_OP_LSL, XRSN_OP_LCIR: begin
        next_extended_working_register[`XRSN_B0] = right_in;
        next_extended_working_register[`XRSN_B1] = extended_working_register[`XRSN_B0];
        next_extended_working_register[`XRSN_B2] = extended_working_register[`XRSN_B1];
        next_extended_working_register[`XRSN_B3] = extended_working_register[`XRSN_B2];
      end
      XRSN_OP_RSA_SS, XRSN_OP_RSL, XRSN_OP_RCIR: begin
        next_extended_working_register[`XRSN_B0] = extended_working_register[`XRSN_B1];
        next_extended_working_register[`XRSN_B1] = extended_working_register[`XRSN_B2];
        next_extended_working_register[`XRSN_B2] = extended_working_register[`XRSN_B3];
        next_extended_working_register[`XRSN_B3] = left_in;
      end
      XRSN_OP_RSA_DS: begin
        next_extended_working_register[`XRSN_B0] = extended_working_register[`XRSN_B1];
        next_extended_working_register[`XRSN_B1] = extended_working_register[`XRSN_B2];
        if (is_top) begin
          next_extended_working_register[`XRSN_B2] = left_in;
          next_extended_working_register[`XRSN_B3] = extended_working_register[`XRSN_B3];
        end else begin
          next_extended_working_register[`XRSN_B2] = extended_working_register[`XRSN_B3];
          next_extended_working_register[`XRSN_B3] = left_in;
        end
      end
      default: begin
        next_extended_working_register = extended_working_register;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // work_reg_input_select
  always_comb begin
    case (i_wr_src)
      XRSN_WR_DATA_IN: next_work_reg = i_data_in;
      XRSN_WR_BUS: next_work_reg = i_data_out_bus_bits;
      default: next_work_reg = work_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // extended register capture
  // capture each edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      extended_working_register <= `XRSN_RST_REG;
    end else begin
      extended_working_register <= next_extended_working_register;
    end
  end

  // working register capture
  // capture each edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      work_reg <= `XRSN_RST_REG;
    end else begin
      work_reg <= next_work_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge selects
  xrsn_edge u_edge (
    .i_ctrl(i_ctrl),
    .i_ext_reg(extended_working_register),
    .i_alu(i_alu),
    .o_left(left_pin),
    .o_right(right_pin)
  );

  assign o_ext_left_shift_port_n = left_pin.out_n;
  assign o_ext_left_shift_port_oe = left_pin.oe;
  assign o_ext_right_shift_port_n = right_pin.out_n;
  assign o_ext_right_shift_port_oe = right_pin.oe;
  assign o_extended_working_register = extended_working_register;
  assign o_work_reg = work_reg;

  ////////////////////////////////////////////////////////////////////////////
  // end-bit outputs of the input select
  // end bits by position
  assign o_ext_msb = is_top ? next_extended_working_register[`XRSN_B3] : `XRSN_FLAG_OFF;
  assign o_ext_lsb = (i_ctrl.pos == XRSN_POS_LEAST) ? next_extended_working_register[`XRSN_B0] : `XRSN_FLAG_OFF;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_left_op;
    xrsn_is_left(i_ctrl.op);
  endsequence
  sequence s_left_done;
    (extended_working_register[`XRSN_B3:`XRSN_B1] == $past(extended_working_register[`XRSN_B2:`XRSN_B0]))
      && (extended_working_register[`XRSN_B0] == $past(right_in));
  endsequence

  property p_load_bus;
    (i_ctrl.op == XRSN_OP_LOAD_BUS) |=> (extended_working_register == $past(i_data_out_bus_bits));
  endproperty
  a_load_bus: assert property (p_load_bus) else $error("bus load not taken");

  property p_left_shift;
    s_left_op |=> s_left_done;
  endproperty
  a_left_shift: assert property (p_left_shift) else $error("left shift wrong");

  property p_right_shift;
    (xrsn_is_right(i_ctrl.op) && !(is_top && i_ctrl.op == XRSN_OP_RSA_DS)) |=>
      (extended_working_register[`XRSN_B2:`XRSN_B0] == $past(extended_working_register[`XRSN_B3:`XRSN_B1]))
      && (extended_working_register[`XRSN_B3] == ~$past(i_ext_left_shift_port_n));
  endproperty
  a_right_shift: assert property (p_right_shift) else $error("right shift wrong");

  property p_double_sign;
    (is_top && i_ctrl.op == XRSN_OP_RSA_DS) |=>
      $stable(extended_working_register[`XRSN_B3])
      && (extended_working_register[`XRSN_B2] == ~$past(i_ext_left_shift_port_n));
  endproperty
  a_double_sign: assert property (p_double_sign) else $error("second sign bit lost");

  property p_left_lower;
    (xrsn_is_left(i_ctrl.op) && !is_top) |->
      o_ext_left_shift_port_oe && (o_ext_left_shift_port_n == ~extended_working_register[`XRSN_B3]);
  endproperty
  a_left_lower: assert property (p_left_lower) else $error("left pin not from bit 3");

  property p_left_top;
    (xrsn_is_left(i_ctrl.op) && is_top) |->
      o_ext_left_shift_port_n == ((i_ctrl.op == XRSN_OP_LCIR) ? ~i_alu[`XRSN_B3] : 1'b0);
  endproperty
  a_left_top: assert property (p_left_top) else $error("top left pin wrong");

  property p_right_pin;
    xrsn_is_right(i_ctrl.op) |-> o_ext_right_shift_port_oe && (o_ext_right_shift_port_n ==
      ~((i_ctrl.pos == XRSN_POS_LEAST) ? i_alu[`XRSN_B0] : extended_working_register[`XRSN_B0]));
  endproperty
  a_right_pin: assert property (p_right_pin) else $error("right pin source wrong");

  property p_idle_pins;
    !(xrsn_is_left(i_ctrl.op) || xrsn_is_right(i_ctrl.op)) |->
      !o_ext_left_shift_port_oe && !o_ext_right_shift_port_oe;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pin driven outside shift");

  property p_work_reg;
    (i_wr_src == XRSN_WR_DATA_IN) |=> (o_work_reg == $past(i_data_in));
  endproperty
  a_work_reg: assert property (p_work_reg) else $error("data-in not loaded");

  property p_end_bits;
    (i_ctrl.op == XRSN_OP_LOAD_BUS && is_top) |-> ##1 $past(o_ext_msb) == o_extended_working_register[`XRSN_B3];
  endproperty
  a_end_bits: assert property (p_end_bits) else $error("msb output mismatch");
endmodule : xrsn_top

// ==== include/xrsn_map.svh ====
// xrsn_map.svh: constants for the extended register shift network
// assumes: included by bare name wherever the network's constants are needed
`ifndef XRSN_MAP_SVH
`define XRSN_MAP_SVH
`define XRSN_WIDTH 4
`define XRSN_B0 0
`define XRSN_B1 1
`define XRSN_B2 2
`define XRSN_B3 3
`define XRSN_RST_REG 4'h0
`define XRSN_PIN_IDLE 1'b1
`define XRSN_EDGE_HIGH 1'b1
`define XRSN_FLAG_OFF 1'b0
`endif

// ==== include/xrsn_pkg.sv ====
// xrsn_pkg: types shared by the extended register shift network
// assumes: compiled before the design modules
package xrsn_pkg;
  // operation in progress, as decoded outside this block
  typedef enum logic [3:0] {
    XRSN_OP_NONE,
    XRSN_OP_LOAD_BUS,
    XRSN_OP_RSA_SS,
    XRSN_OP_RSA_DS,
    XRSN_OP_RSL,
    XRSN_OP_RCIR,
    XRSN_OP_LSA_SS,
    XRSN_OP_LSA_DS,
    XRSN_OP_LSL,
    XRSN_OP_LCIR
  } xrsn_op_t;
  // slice position in the chain
  typedef enum logic [1:0] {
    XRSN_POS_MOST,
    XRSN_POS_INTER,
    XRSN_POS_LEAST
  } xrsn_pos_t;
  // working register source
  typedef enum logic [1:0] {
    XRSN_WR_HOLD,
    XRSN_WR_DATA_IN,
    XRSN_WR_BUS
  } xrsn_wr_src_t;
  typedef struct packed {
    xrsn_op_t op;
    xrsn_pos_t pos;
  } xrsn_ctrl_t;
  // one shift pin: level at the pin (active low) and its enable
  typedef struct packed {
    logic out_n;
    logic oe;
  } xrsn_pin_t;
  // true for the four double-precision left operations
  function automatic logic xrsn_is_left(input xrsn_op_t op);
    return (op == XRSN_OP_LSA_SS) || (op == XRSN_OP_LSA_DS) || (op == XRSN_OP_LSL) || (op == XRSN_OP_LCIR);
  endfunction : xrsn_is_left
  // true for the four double-precision right operations
  function automatic logic xrsn_is_right(input xrsn_op_t op);
    return (op == XRSN_OP_RSA_SS) || (op == XRSN_OP_RSA_DS) || (op == XRSN_OP_RSL) || (op == XRSN_OP_RCIR);
  endfunction : xrsn_is_right
endpackage : xrsn_pkg

// ==== test/tb.sv ====
// tb: self-checking bench for the extended register shift network
// assumes: one slice, with neighbour models on both shift pins
`timescale 1ns/1ps
module tb;
  import xrsn_pkg::*;
  typedef struct {xrsn_op_t op; xrsn_pos_t pos; logic lft; logic [3:0] x; logic [3:0] alu; logic nb;
    logic [3:0] ex; logic eo;} xrsn_row_t;
  logic clk, reset_n, nb_bit, nb_l_drv, nb_r_drv, left_in_n, right_in_n;
  logic lo_n, lo_oe, ro_n, ro_oe, msb, lsb;
  xrsn_ctrl_t ctrl;
  xrsn_wr_src_t wr_src;
  logic [3:0] din, bus, alu, ext_reg, wr, pins;
  int fails = 0;
  int compares = 0;
  xrsn_row_t r;
  // op, position, left?, start, alu, inbound bit, next register, outbound bit
  xrsn_row_t rows [13] = '{
    '{XRSN_OP_LSA_SS, XRSN_POS_MOST, 1, 4'hA, 4'h0, 1, 4'h5, 1},
    '{XRSN_OP_LSA_DS, XRSN_POS_MOST, 1, 4'h5, 4'h0, 0, 4'hA, 1},
    '{XRSN_OP_LSL, XRSN_POS_MOST, 1, 4'hC, 4'hF, 1, 4'h9, 1},
    '{XRSN_OP_LCIR, XRSN_POS_MOST, 1, 4'h3, 4'h7, 0, 4'h6, 0},
    '{XRSN_OP_LCIR, XRSN_POS_INTER, 1, 4'h8, 4'h0, 1, 4'h1, 1},
    '{XRSN_OP_LSL, XRSN_POS_LEAST, 1, 4'h7, 4'h8, 1, 4'hF, 0},
    '{XRSN_OP_RSA_SS, XRSN_POS_MOST, 0, 4'h6, 4'h0, 1, 4'hB, 0},
    '{XRSN_OP_RSA_DS, XRSN_POS_MOST, 0, 4'h9, 4'h0, 0, 4'h8, 1},
    '{XRSN_OP_RSL, XRSN_POS_MOST, 0, 4'h5, 4'h0, 1, 4'hA, 1},
    '{XRSN_OP_RCIR, XRSN_POS_INTER, 0, 4'h2, 4'hF, 0, 4'h1, 0},
    '{XRSN_OP_RSA_DS, XRSN_POS_LEAST, 0, 4'h9, 4'hE, 1, 4'hC, 0},
    '{XRSN_OP_RSA_DS, XRSN_POS_INTER, 0, 4'h1, 4'h0, 0, 4'h0, 1},
    '{XRSN_OP_RSL, XRSN_POS_LEAST, 0, 4'h4, 4'h1, 0, 4'h2, 1}
  };
  ////////////////////////////////////////////////////////////////////////
  xrsn_top DUT (.i_ref_clk(clk), .i_reset_n(reset_n), .i_ctrl(ctrl), .i_wr_src(wr_src),
    .i_data_in(din), .i_data_out_bus_bits(bus), .i_alu(alu),
    .i_ext_left_shift_port_n(left_in_n), .o_ext_left_shift_port_n(lo_n),
    .o_ext_left_shift_port_oe(lo_oe), .i_ext_right_shift_port_n(right_in_n),
    .o_ext_right_shift_port_n(ro_n), .o_ext_right_shift_port_oe(ro_oe),
    .o_extended_working_register(ext_reg), .o_work_reg(wr), .o_ext_msb(msb), .o_ext_lsb(lsb));
  xrsn_nbr left_nbr (.i_ref_clk(clk), .i_drive(nb_l_drv), .i_bit(nb_bit), .i_own_oe(lo_oe),
    .i_own_n(lo_n), .o_wire_n(left_in_n));
  xrsn_nbr right_nbr (.i_ref_clk(clk), .i_drive(nb_r_drv), .i_bit(nb_bit), .i_own_oe(ro_oe),
    .i_own_n(ro_n), .o_wire_n(right_in_n));
  ////////////////////////////////////////////////////////////////////////
  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one comparison, counted
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // watchdog against a hang
  initial begin
    #20000;
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence: table rows, then working register and reset
  initial begin
    reset_n = 1'b0;
    ctrl = '{XRSN_OP_NONE, XRSN_POS_INTER};
    wr_src = XRSN_WR_HOLD;
    din = 4'h0;
    bus = 4'h0;
    alu = 4'h0;
    nb_bit = 1'b0;
    nb_l_drv = 1'b0;
    nb_r_drv = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      ctrl <= '{XRSN_OP_LOAD_BUS, r.pos};
      bus <= r.x;
      @(posedge clk);
      ctrl <= '{r.op, r.pos};
      alu <= r.alu;
      nb_bit <= r.nb;
      nb_l_drv <= !r.lft;
      nb_r_drv <= r.lft;
      #1;
      chk("load", r.x, ext_reg);
      pins = r.lft ? {1'b1, ~r.eo, 2'b01} : {2'b01, 1'b1, ~r.eo};
      chk("pins", pins, {lo_oe, lo_n, ro_oe, ro_n});
      chk("msb_lsb", {2'b00, r.pos == XRSN_POS_MOST ? r.ex[3] : 1'b0, r.pos == XRSN_POS_LEAST ? r.ex[0] : 1'b0},
        {2'b00, msb, lsb});
      @(posedge clk);
      ctrl <= '{XRSN_OP_NONE, r.pos};
      nb_l_drv <= 1'b0;
      nb_r_drv <= 1'b0;
      #1;
      chk("shift", r.ex, ext_reg);
    end
    // working register sources, idle pins and hold
    @(posedge clk);
    wr_src <= XRSN_WR_DATA_IN;
    din <= 4'h6;
    bus <= 4'h9;
    @(posedge clk);
    wr_src <= XRSN_WR_BUS;
    #1;
    chk("wr_din", 4'h6, wr);
    chk("idle_pins", 4'b0101, {lo_oe, lo_n, ro_oe, ro_n});
    @(posedge clk);
    wr_src <= XRSN_WR_HOLD;
    #1;
    chk("wr_bus", 4'h9, wr);
    // reset in mid-run wins over a pending load of both registers
    @(posedge clk);
    reset_n <= 1'b0;
    ctrl <= '{XRSN_OP_LOAD_BUS, XRSN_POS_INTER};
    wr_src <= XRSN_WR_DATA_IN;
    #1;
    chk("wr_hold", 4'h9, wr);
    chk("ext_hold", 4'h2, ext_reg);
    @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("rst_ext", 4'h0, ext_reg);
    chk("rst_wr", 4'h0, wr);
    // first edge after release takes the pending loads
    @(posedge clk);
    #1;
    chk("rel_ext", 4'h9, ext_reg);
    chk("rel_wr", 4'h6, wr);
    conclude();
  end
endmodule : tb

// ==== test/xrsn_nbr.sv ====
// xrsn_nbr: behavioural neighbour slice on the far side of one shift pin
// assumes: the bench says when the neighbour drives and with which bit
`timescale 1ns/1ps
module xrsn_nbr (
  input wire logic i_ref_clk,
  input wire logic i_drive,
  input wire logic i_bit,
  input wire logic i_own_oe,
  input wire logic i_own_n,
  output logic o_wire_n
);
  logic last = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // released wire shows a changing pattern, never a stale value
  always_ff @(posedge i_ref_clk) begin
    last <= o_wire_n;
  end
  // inverted wire level
  // own slice wins, else the neighbour drives its bit active low
  assign o_wire_n = i_own_oe ? i_own_n : (i_drive ? ~i_bit : ~last);
endmodule : xrsn_nbr
